//--- core/dau_core.sv
// Purpose: Six-channel converter input registers, update sequencing and I/O decode behind AHB-Lite.
// Assumes: Single word transfers; inputs synchronous to hclk; switch inputs are 1 when ON.
// Notes: Every transfer to the block takes three data-phase cycles, hreadyout low for two.
`timescale 1ns/1ps
module dau_core #(
  parameter int NUM_CH = dau_pkg::DAU_NUM_CH,
  parameter int NUM_PAIRS = dau_pkg::DAU_NUM_PAIRS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout_q,
  output logic hresp_q,
  output logic [31:0] hrdata_q,
  // Static switches
  input wire logic [dau_pkg::DAU_SW_W-1:0] base_addr_switch_on,
  input wire logic [dau_pkg::DAU_SW_W-1:0] update_mode_switch_bank,
  // External update lines (port C upper) and their gates (port C lower)
  input wire logic [NUM_PAIRS-1:0] ext_update_n,
  input wire logic [NUM_PAIRS-1:0] ext_update_gate,
  // Converter latches
  output logic [NUM_CH-1:0][dau_pkg::DAU_DAC_W-1:0] dac_code_q,
  output logic [NUM_CH-1:0] dac_load_q,
  // Parallel port access strobes
  output logic ppi_wr_q,
  output logic ppi_rd_q,
  output logic [1:0] ppi_addr_q,
  output logic [7:0] ppi_wdata_q,
  input wire logic [7:0] ppi_rdata
);

  localparam int OFS_W = dau_pkg::DAU_OFS_MSB - dau_pkg::DAU_OFS_LSB + 1;

  // Offsets 0 to 11 belong to the converters.
  function automatic logic is_dac_ofs(input logic [OFS_W-1:0] ofs);
    return ofs <= dau_pkg::DAU_OFS_DAC_LAST;
  endfunction

  // A switch that is ON asks for a zero on its address bit, OFF asks for a one.
  function automatic logic base_match(input logic [dau_pkg::DAU_SW_W-1:0] abits,
                                      input logic [dau_pkg::DAU_SW_W-1:0] sw_on);
    return abits == ~sw_on;
  endfunction

  dau_pkg::dau_state_t state_q;
  dau_pkg::dau_state_t state_d;
  logic hit_q;
  logic hit_d;
  logic wr_q;
  logic wr_d;
  logic [OFS_W-1:0] ofs_q;
  logic [OFS_W-1:0] ofs_d;
  logic hreadyout_d;
  logic [31:0] hrdata_d;
  logic ppi_wr_d;
  logic ppi_rd_d;
  logic [1:0] ppi_addr_d;
  logic [7:0] ppi_wdata_d;
  logic accept;

  logic [NUM_CH-1:0][dau_pkg::DAU_DAC_W-1:0] in_code_q;
  logic [NUM_CH-1:0][dau_pkg::DAU_DAC_W-1:0] in_code_d;
  logic [NUM_CH-1:0][dau_pkg::DAU_DAC_W-1:0] dac_code_d;
  logic [NUM_CH-1:0] dac_load_d;

  logic [NUM_PAIRS-1:0] ex_en;
  logic [NUM_PAIRS-1:0] sm_en;
  logic [NUM_PAIRS-1:0] ext_fall;
  logic act_wr_dac;
  logic act_rd_dac;
  logic [NUM_CH-1:0] hi_write;

  // Only ON switches count; each pair has its own enable bits.
  assign ex_en = update_mode_switch_bank[dau_pkg::DAU_MODE_EX_LSB +: NUM_PAIRS];
  assign sm_en = update_mode_switch_bank[dau_pkg::DAU_MODE_SM_LSB +: NUM_PAIRS];

  assign accept = hsel & hready & htrans[1];

  dau_edge #(
    .N(NUM_PAIRS)
  ) u_edge (
    .clk(hclk),
    .rst_n(hresetn),
    .level(ext_update_n),
    .fall(ext_fall)
  );

  // Bus sequencing: capture address phase, act in the first data cycle, answer in the second.
  always_comb begin
    state_d = state_q;
    hit_d = hit_q;
    wr_d = wr_q;
    ofs_d = ofs_q;
    hreadyout_d = hreadyout_q;
    hrdata_d = hrdata_q;
    unique case (state_q)
      dau_pkg::DAU_ST_IDLE: begin
        if (accept) begin
          hit_d = base_match(haddr[dau_pkg::DAU_BASE_MSB:dau_pkg::DAU_BASE_LSB],
                             base_addr_switch_on);
          wr_d = hwrite;
          ofs_d = haddr[dau_pkg::DAU_OFS_MSB:dau_pkg::DAU_OFS_LSB];
          hreadyout_d = 1'b0;
          state_d = dau_pkg::DAU_ST_ACT;
        end
      end
      dau_pkg::DAU_ST_ACT: begin
        state_d = dau_pkg::DAU_ST_RESP;
      end
      dau_pkg::DAU_ST_RESP: begin
        // Converter reads and unmapped reads answer zero; software must not use it.
        hrdata_d = ppi_rd_q ? {24'h00_0000, ppi_rdata} : dau_pkg::DAU_RDATA_RESET;
        hreadyout_d = 1'b1;
        state_d = dau_pkg::DAU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= dau_pkg::DAU_ST_IDLE;
      hit_q <= 1'b0;
      wr_q <= 1'b0;
      ofs_q <= '0;
      hreadyout_q <= 1'b1;
      hresp_q <= dau_pkg::DAU_HRESP_OKAY;
      hrdata_q <= dau_pkg::DAU_RDATA_RESET;
    end else begin
      state_q <= state_d;
      hit_q <= hit_d;
      wr_q <= wr_d;
      ofs_q <= ofs_d;
      hreadyout_q <= hreadyout_d;
      hresp_q <= dau_pkg::DAU_HRESP_OKAY;
      hrdata_q <= hrdata_d;
    end
  end

  // Parallel port strobes last one cycle, during the response cycle of the transfer.
  always_comb begin
    ppi_wr_d = 1'b0;
    ppi_rd_d = 1'b0;
    ppi_addr_d = ppi_addr_q;
    ppi_wdata_d = ppi_wdata_q;
    if (state_q == dau_pkg::DAU_ST_ACT && hit_q && !is_dac_ofs(ofs_q)) begin
      ppi_wr_d = wr_q;
      ppi_rd_d = !wr_q;
      ppi_addr_d = ofs_q[1:0];
      ppi_wdata_d = hwdata[dau_pkg::DAU_BYTE_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ppi_wr_q <= 1'b0;
      ppi_rd_q <= 1'b0;
      ppi_addr_q <= 2'h0;
      ppi_wdata_q <= 8'h00;
    end else begin
      ppi_wr_q <= ppi_wr_d;
      ppi_rd_q <= ppi_rd_d;
      ppi_addr_q <= ppi_addr_d;
      ppi_wdata_q <= ppi_wdata_d;
    end
  end

  assign act_wr_dac = (state_q == dau_pkg::DAU_ST_ACT) && hit_q && wr_q && is_dac_ofs(ofs_q);
  assign act_rd_dac = (state_q == dau_pkg::DAU_ST_ACT) && hit_q && !wr_q && is_dac_ofs(ofs_q);

  // Input registers take the written bytes; converter latches follow only on an update event.
  always_comb begin
    in_code_d = in_code_q;
    dac_code_d = dac_code_q;
    dac_load_d = '0;
    hi_write = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (act_wr_dac && (ofs_q[OFS_W-1:1] == (OFS_W-1)'(c))) begin
        if (ofs_q[0]) begin
          // High byte holds the top nibble in its low bits; the rest is ignored.
          in_code_d[c][dau_pkg::DAU_DAC_W-1:dau_pkg::DAU_LO_W] = hwdata[dau_pkg::DAU_HI_W-1:0];
          hi_write[c] = 1'b1;
        end else begin
          in_code_d[c][dau_pkg::DAU_LO_W-1:0] = hwdata[dau_pkg::DAU_LO_W-1:0];
        end
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // Each pair looks only at its own enables, so modes mix freely.
      if ((hi_write[c] && !ex_en[c/2] && !sm_en[c/2])
          || (act_rd_dac && sm_en[c/2])
          || (ext_fall[c/2] && ex_en[c/2] && ext_update_gate[c/2])) begin
        dac_code_d[c] = in_code_d[c];
        dac_load_d[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_code_q <= {NUM_CH{dau_pkg::DAU_CODE_RESET}};
      dac_code_q <= {NUM_CH{dau_pkg::DAU_CODE_RESET}};
      dac_load_q <= '0;
    end else begin
      in_code_q <= in_code_d;
      dac_code_q <= dac_code_d;
      dac_load_q <= dac_load_d;
    end
  end

  // The transfer size is not checked: only whole words are issued to this block.
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:dau_pkg::DAU_BASE_MSB+1], haddr[1:0], hwdata[31:dau_pkg::DAU_BYTE_W]};

endmodule

//--- core/dau_edge.sv
// Purpose: Falling edge detection on the external update inputs.
// Assumes: Inputs are synchronous to the clock.
// Notes: Output pulse is combinational from the stored previous level.
`timescale 1ns/1ps
module dau_edge #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels and detected edges
  input wire logic [N-1:0] level,
  output logic [N-1:0] fall
);

  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;

  // Reset to high, so an input held low through reset counts as an edge in the first cycle after reset.
  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '1;
    end else begin
      prev_q <= prev_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_fall
      assign fall[g] = prev_q[g] & ~level[g];
    end
  endgenerate

endmodule

//--- core/dau_pkg.sv
// Purpose: Shared constants and types for the analog output update and I/O decode block.
// Assumes: AHB-Lite word access; each 8-bit I/O location takes one aligned 32-bit word.
// Notes: Byte address of a location is four times its I/O address within the decoded field.
// Functional notes
// - The update mode comes from six static switch inputs, each active only when its switch is ON.
// - A pair with neither enable active loads a channel's converter at once on a write of its high byte.
// - Enable pair 0 governs channels 0 and 1, pair 1 channels 2 and 3, pair 2 channels 4 and 5.
// - Pairs with the software enable active load their converters together on a read of any converter address.
// - Pairs with the external enable active load both converters together on a falling edge of their update input.
// - Each pair's external update is gated by one of the port C lower lines 0 to 2.
// - The device answers a block of sixteen consecutive I/O addresses from its base.
// - The block is selected by comparing I/O address bits 9 to 4 with six base switches.
// - A base switch OFF requires a one on its address bit and ON requires a zero.
// - I/O address bits 3 to 0 pick the location inside the block.
// - Offsets 0 to 11 take channel data, even low byte and odd high byte; 12 to 15 go to the parallel port.
// - Codes are right justified: high byte bits 3 to 0 are the top nibble, the low byte the rest.
// - Channel pairs in different update modes do not disturb each other.
package dau_pkg;

  localparam int DAU_NUM_CH = 6;
  localparam int DAU_NUM_PAIRS = 3;
  localparam int DAU_DAC_W = 12;
  localparam int DAU_LO_W = 8;
  localparam int DAU_HI_W = 4;
  localparam int DAU_BYTE_W = 8;
  localparam int DAU_DATA_W = 32;
  localparam int DAU_SW_W = 6;

  // Byte address fields: I/O bits 3..0 sit at haddr 5..2, I/O bits 9..4 at haddr 11..6.
  localparam int DAU_OFS_LSB = 2;
  localparam int DAU_OFS_MSB = 5;
  localparam int DAU_BASE_LSB = 6;
  localparam int DAU_BASE_MSB = 11;

  localparam logic [3:0] DAU_OFS_DAC_LAST = 4'hB;
  localparam logic [3:0] DAU_OFS_PPI_FIRST = 4'hC;

  // Update mode switch bank layout: external enables first, then software enables.
  localparam int DAU_MODE_EX_LSB = 0;
  localparam int DAU_MODE_SM_LSB = 3;

  localparam logic DAU_HRESP_OKAY = 1'b0;
  localparam logic [DAU_DATA_W-1:0] DAU_RDATA_RESET = 32'h0000_0000;
  localparam logic [DAU_DAC_W-1:0] DAU_CODE_RESET = 12'h000;

  typedef enum logic [1:0] {
    DAU_ST_IDLE,
    DAU_ST_ACT,
    DAU_ST_RESP
  } dau_state_t;

endpackage

//--- test/dau_core_properties.sv
// Purpose: Port-level checks of bus timing, decode and update sequencing.
// Assumes: hready is fed from hreadyout_q; one clock domain.
// Notes: Pair 0 stands in for the other pairs to keep the checker small.
`timescale 1ns/1ps
module dau_core_props #(
  parameter int NUM_CH = 6,
  parameter int NUM_PAIRS = 3
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout_q,
  // Switches and external lines
  input wire logic [5:0] base_addr_switch_on,
  input wire logic [5:0] update_mode_switch_bank,
  input wire logic [NUM_PAIRS-1:0] ext_update_n,
  input wire logic [NUM_PAIRS-1:0] ext_update_gate,
  // Results
  input wire logic [NUM_CH-1:0][11:0] dac_code_q,
  input wire logic [NUM_CH-1:0] dac_load_q,
  input wire logic ppi_wr_q,
  input wire logic ppi_rd_q
);
  wire [3:0] ofs = haddr[5:2];
  wire hit = haddr[11:6] == ~base_addr_switch_on;
  wire [5:0] md = update_mode_switch_bank;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take;
    hsel && hready && htrans[1] && hreadyout_q;
  endsequence
  sequence s_wait;
    !hreadyout_q ##1 !hreadyout_q ##1 hreadyout_q;
  endsequence
  a_data_phase: assert property (s_take |=> s_wait)
    else $error("data phase length wrong");
  a_miss_quiet: assert property (s_take ##0 (!hit && md == 6'h00) |=> ##1 !ppi_wr_q && !ppi_rd_q && !dac_load_q)
    else $error("miss caused an action");
  a_port_write: assert property (s_take ##0 (hit && hwrite && ofs >= 4'hC) |=> ##1 ppi_wr_q ##1 !ppi_wr_q)
    else $error("port write strobe wrong");
  a_port_read: assert property (s_take ##0 (hit && !hwrite && ofs >= 4'hC) |=> ##1 ppi_rd_q ##1 !ppi_rd_q)
    else $error("port read strobe wrong");
  a_high_loads: assert property (s_take ##0 (hit && hwrite && ofs == 4'h1 && !md[0] && !md[3]) |=> ##1 dac_load_q[0])
    else $error("high byte did not load");
  a_low_waits: assert property (s_take ##0 (hit && hwrite && ofs == 4'h0 && !md[0] && !md[3]) |=> ##1 !dac_load_q[0])
    else $error("low byte loaded");
  a_code_holds: assert property (!dac_load_q[0] |-> $stable(dac_code_q[0]))
    else $error("code moved without load");
  a_sw_read: assert property (s_take ##0 (hit && !hwrite && ofs <= 4'hB && md[3]) |=> ##1 dac_load_q[1:0] == 2'h3)
    else $error("read did not load pair");
  a_ext_fall: assert property ($fell(ext_update_n[0]) && ext_update_gate[0] && md[0] |=> dac_load_q[1:0] == 2'h3)
    else $error("falling edge did not load pair");
  a_gate_blocks: assert property ($fell(ext_update_n[0]) && !ext_update_gate[0] && md == 6'h01 |=> !dac_load_q[0])
    else $error("gated edge loaded");
endmodule
bind dau_core dau_core_props #(.NUM_CH(NUM_CH), .NUM_PAIRS(NUM_PAIRS)) u_dau_core_props (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout_q, .base_addr_switch_on, .update_mode_switch_bank, .ext_update_n,
  .ext_update_gate, .dac_code_q, .dac_load_q, .ppi_wr_q, .ppi_rd_q);

//--- test/dau_ppi_model.sv
// Purpose: Stand-in for the parallel port behind offsets 12 to 15.
// Assumes: Strobes are one-cycle pulses on clk.
// Notes: Outside a read the data lines show the inverse, so a late sample is caught.
`timescale 1ns/1ps
module dau_ppi_model (
  // Clock
  input wire logic clk,
  // Port access
  input wire logic wr,
  input wire logic rd,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [4] = '{default: 8'h00};
  always @(posedge clk) if (wr) mem[addr] <= wdata;
  assign rdata = rd ? mem[addr] : ~mem[addr];
endmodule

//--- test/tb_dau_core.sv
// Purpose: Self-checking bench for decode and update modes over AHB-Lite.
// Assumes: Base switches give I/O base 2D0; hready is hreadyout_q.
// Notes: Codes start at 930 plus 101 per channel.
`timescale 1ns/1ps
module tb_dau_core;
  logic hclk, hresetn, hwrite, hreadyout_q, hresp_q, ppi_wr_q, ppi_rd_q;
  logic [1:0] htrans, ppi_addr_q;
  logic [31:0] haddr, hwdata, hrdata_q, rd;
  logic [5:0] base_addr_switch_on, update_mode_switch_bank, dac_load_q;
  logic [2:0] ext_update_n, ext_update_gate;
  logic [5:0][11:0] dac_code_q;
  logic [7:0] ppi_wdata_q, ppi_rdata;
  int err_total, n_tests;
  localparam logic [5:0] BF = 6'h2D;
  dau_core u_dau_core (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout_q), .hreadyout_q, .hresp_q, .hrdata_q, .base_addr_switch_on, .update_mode_switch_bank,
    .ext_update_n, .ext_update_gate, .dac_code_q, .dac_load_q, .ppi_wr_q, .ppi_rd_q, .ppi_addr_q,
    .ppi_wdata_q, .ppi_rdata);
  dau_ppi_model u_dau_ppi_model (.clk(hclk), .wr(ppi_wr_q), .rd(ppi_rd_q), .addr(ppi_addr_q),
    .wdata(ppi_wdata_q), .rdata(ppi_rdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic waitrdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout_q !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      results();
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] fld, input logic [3:0] ofs, input logic [7:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, fld, ofs, 2'h0};
    waitrdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitrdy();
    rd = hrdata_q;
    chk("resp", 32'(hresp_q), 32'h0);
  endtask
  task automatic ld(input int c, input logic [11:0] v);
    xfer(1'b1, BF, 4'(2 * c), v[7:0]);
    xfer(1'b1, BF, 4'(2 * c + 1), {4'hF, v[11:8]});
  endtask
  task automatic fall(input int p);
    ext_update_n[p] <= 1'b0;
    repeat (2) @(posedge hclk);
    ext_update_n[p] <= 1'b1;
    @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    base_addr_switch_on = ~BF;
    update_mode_switch_bank = 6'h00;
    ext_update_n = 3'h7;
    ext_update_gate = 3'h0;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int c = 0; c < 6; c++) begin
      xfer(1'b1, BF, 4'(2 * c), 8'(8'h30 + c));
      chk("low only", 32'(dac_code_q[c]), 32'h0);
      xfer(1'b1, BF, 4'(2 * c + 1), 8'(8'hF9 + c));
      chk("high loads", 32'(dac_code_q[c]), 32'(32'h930 + 32'h101 * c));
    end
    $display("test immediate done");
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, BF ^ (6'h01 << i), 4'h1, 8'h05);
      chk("miss", 32'(dac_code_q[0]), 32'h930);
    end
    $display("test decode done");
    update_mode_switch_bank <= 6'h08;
    ld(0, 12'h5A5);
    ld(1, 12'hA5A);
    ld(2, 12'h123);
    chk("sw held", 32'(dac_code_q[0]), 32'h930);
    chk("mixed pair", 32'(dac_code_q[2]), 32'h123);
    xfer(1'b0, BF, 4'hB, 8'h00);
    chk("sw ch0", 32'(dac_code_q[0]), 32'h5A5);
    chk("sw ch1", 32'(dac_code_q[1]), 32'hA5A);
    $display("test software done");
    update_mode_switch_bank <= 6'h04;
    ld(4, 12'h3C3);
    ld(5, 12'hC3C);
    fall(2);
    chk("gated", 32'(dac_code_q[4]), 32'hD34);
    ext_update_gate <= 3'h4;
    fall(2);
    chk("ext ch4", 32'(dac_code_q[4]), 32'h3C3);
    chk("ext ch5", 32'(dac_code_q[5]), 32'hC3C);
    // Pair 0 on its own external edge, so the pair 0 checks see both a gated and an open edge.
    update_mode_switch_bank <= 6'h01;
    ld(0, 12'h0F0);
    ld(1, 12'h707);
    fall(0);
    chk("gated ch0", 32'(dac_code_q[0]), 32'h5A5);
    ext_update_gate <= 3'h1;
    fall(0);
    chk("ext ch0", 32'(dac_code_q[0]), 32'h0F0);
    chk("ext ch1", 32'(dac_code_q[1]), 32'h707);
    chk("other pair", 32'(dac_code_q[4]), 32'h3C3);
    $display("test external done");
    for (int k = 12; k < 16; k++) xfer(1'b1, BF, 4'(k), 8'(8'hC0 + k));
    for (int k = 12; k < 15; k++) begin
      xfer(1'b0, BF, 4'(k), 8'h00);
      chk("port read", rd, 32'(8'hC0 + k));
    end
    $display("test port done");
    results();
  end
endmodule
